// ===== rtl/addr_gen_decode.v
/*
 * Instruction decoder of the address generator: mode word, alternate
 * instruction holder, opcode decode, data pass and bit-reversed output.
 * Assumes a sequencer drives the instruction bus each clock and one clock.
 */
// Notes on behaviour
// - Holder loads from data or instruction bus.
// - Load-alternate captures next word, no-op instead.
// - Next-cycle load only with chip select.
// - Control reset after load-alternate still executes.
// - Holder runs on enable or conditional compare.
// - Read-alternate drives holder on data 9..0.
// - Write-alternate loads holder from data 9..0.
// - No-op keeps state, floats both buses.
// - Pass opcode copies data bus to address.
// - Bit-reverse outputs reversed value, stores sum.
// - Offset index third bit from offset bank.
// - Address index fourth bit from address bank for add and subtract.
// - Mode bits 5..4 select precision.
// - Mode bit 6 selects transparent output.
// - Bits 7 and 8 pick register banks.
// - Mode bit 10 enables conditional alternate.
// - Decode looping group opcodes.
// - Decode register transfer group opcodes.
// - Decode logic and shift group opcodes.
// - Decode single-bit mode set opcodes.
// - Control reset wins; from holder is no-op.
// - Chip select swaps precision bits 01/10.
// - Conditional mode runs holder, blocks reinit.
`timescale 1ns/1ps
`include "addr_gen_defs.vh"
module addr_gen_decode #(
    parameter DW = 16,
    parameter IW = 10
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rst_b,
    // Instruction bus and controls
    input  wire [IW-1:0] instr_in,
    input  wire          chip_select_in,
    input  wire          alternate_exec_enable_in,
    input  wire          compare_true_in,
    // Data bus, three signals
    input  wire [DW-1:0] data_in,
    output reg  [DW-1:0] data_out,
    output reg           data_oe,
    // Address output
    output reg  [DW-1:0] addr_out,
    output reg           addr_oe,
    // Mode word state
    output wire [10:0]   mode_control_word,
    output wire [1:0]    precision_mode,
    output wire          transparent_mode,
    output wire          reinit_allowed,
    // Decoded group and register indices for the datapath
    output reg  [4:0]    op_class,
    output reg  [3:0]    areg_index,
    output reg  [2:0]    oreg_index,
    output reg  [1:0]    cnt_index
);
    // Decoded operation classes
    localparam C_NONE = 5'h00, C_INC = 5'h01, C_DEC = 5'h02, C_ADD = 5'h03, C_SUB = 5'h04;
    localparam C_BTD = 5'h05, C_BTR = 5'h06, C_CTD = 5'h07, C_DTI = 5'h08, C_ITD = 5'h09;
    localparam C_ITR = 5'h0A, C_RTD = 5'h0B, C_YRTB = 5'h0C, C_YRTC = 5'h0D, C_YRTR = 5'h0E;
    localparam C_AND = 5'h0F, C_OR = 5'h10, C_XOR = 5'h11, C_ASR = 5'h12, C_LSL = 5'h13;
    localparam C_REV = 5'h14, C_PASS = 5'h15, C_MODE = 5'h16, C_ALT = 5'h17;

    reg  [10:0]   mode_reg;
    reg  [10:0]   mode_next;
    reg  [IW-1:0] alternate_instruction_holder;
    reg  [IW-1:0] alt_next;
    reg           load_pending_reg;
    reg           cond_fire_reg;
    reg  [DW-1:0] areg [0:15];
    reg  [DW-1:0] oreg [0:7];
    reg  [IW-1:0] exec_word;
    reg           exec_valid;
    reg  [DW-1:0] sum_val;
    reg  [DW-1:0] rev_src;
    wire [DW-1:0] rev_val;
    integer       k;

    assign mode_control_word = mode_reg;
    assign precision_mode    = mode_reg[`MODE_PREC_MSB:`MODE_PREC_LSB];
    assign transparent_mode  = mode_reg[`MODE_TRANSP];
    assign reinit_allowed    = ~mode_reg[`MODE_CONDALT];

    // Four-bit address index with bank bit when only three given
    function [3:0] a_idx3;
        input [2:0] r;
        input       bank;
        a_idx3 = {bank, r};
    endfunction

    // Three-bit offset index with bank bit
    function [2:0] o_idx2;
        input [1:0] b;
        input       bank;
        o_idx2 = {bank, b};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pick the word to execute this cycle
    always @* begin
        exec_word  = instr_in;
        exec_valid = 1'b1;
        if (load_pending_reg && instr_in != `OP_CTRL_RESET) begin
            exec_valid = 1'b0;
        end else if (instr_in == `OP_CTRL_RESET) begin
            exec_word = instr_in;
        end else if (alternate_exec_enable_in || cond_fire_reg) begin
            exec_word = alternate_instruction_holder;
            if (alternate_instruction_holder == `OP_CTRL_RESET)
                exec_valid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Opcode map decode
    always @* begin
        op_class   = C_NONE;
        areg_index = exec_word[3:0];
        oreg_index = o_idx2(exec_word[5:4], mode_reg[`MODE_OBANK]);
        cnt_index  = exec_word[5:4];
        if (!exec_valid) begin
            op_class = C_NONE;
        end else if (exec_word[9:8] == 2'b11) begin
            op_class   = exec_word[3] ? C_ADD : C_SUB;
            areg_index = a_idx3(exec_word[2:0], mode_reg[`MODE_ABANK]);
            oreg_index = o_idx2(exec_word[5:4], mode_reg[`MODE_OBANK]);
            cnt_index  = {1'b0, exec_word[6]};
        end else if (exec_word[9:6] == 4'hB) begin
            op_class = C_INC;
        end else if (exec_word[9:6] == 4'hA) begin
            op_class = C_DEC;
        end else if (exec_word[9:6] == 4'h9) begin
            op_class = C_REV;
        end else if (exec_word[9:6] == 4'h8) begin
            op_class = C_ITR;
        end else if (exec_word[9:6] == 4'h7) begin
            op_class = C_OR;
        end else if (exec_word[9:6] == 4'h6) begin
            op_class = C_AND;
        end else if (exec_word[9:6] == 4'h5) begin
            op_class = C_XOR;
        end else if (exec_word[9:6] == 4'h4) begin
            op_class = C_BTR;
        end else if (exec_word[9:6] == 4'h3) begin
            op_class = C_YRTB;
        end else if (exec_word[9:6] == 4'h2) begin
            op_class = C_YRTC;
        end else if (exec_word[9:4] == 6'h07) begin
            op_class = C_ASR;
        end else if (exec_word[9:4] == 6'h06) begin
            op_class = C_LSL;
        end else if (exec_word[9:4] == 6'h05) begin
            op_class = C_YRTR;
        end else if (exec_word[9:4] == 6'h04) begin
            op_class = C_RTD;
        end else if (exec_word[9:2] == 8'h0D) begin
            op_class = C_BTD;
            oreg_index = o_idx2(exec_word[1:0], mode_reg[`MODE_OBANK]);
        end else if (exec_word[9:2] == 8'h0C) begin
            op_class  = C_CTD;
            cnt_index = exec_word[1:0];
        end else if (exec_word[9:2] == 8'h0F) begin
            op_class  = C_DTI;
            cnt_index = exec_word[1:0];
        end else if (exec_word[9:2] == 8'h0E) begin
            op_class  = C_ITD;
            cnt_index = exec_word[1:0];
        end else if (exec_word == `OP_DATA_TO_ADDR) begin
            op_class = C_PASS;
        end else if (exec_word == `OP_WRITE_ALT || exec_word == `OP_READ_ALT
                     || exec_word == `OP_LOAD_ALT) begin
            op_class = C_ALT;
        end else if (exec_word != `OP_NOP) begin
            op_class = C_MODE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode word next value
    always @* begin
        mode_next = mode_reg;
        if (exec_valid) begin
            if (exec_word == `OP_CTRL_RESET) begin
                mode_next = `MODE_RESET;
            end else if (exec_word == `OP_DATA_TO_MODE) begin
                mode_next = data_in[10:0];
            end else if (exec_word[9:1] == 9'h00A) begin
                mode_next[`MODE_CONDALT] = exec_word[0];
            end else if (exec_word[9:3] == 7'h04) begin
                mode_next[exec_word[2:1]] = exec_word[0];
            end else if (exec_word[9:2] == 8'h0A) begin
                // MS chip of a pair is told by chip select, same opcode
                if (chip_select_in && (exec_word[1:0] == 2'b01 || exec_word[1:0] == 2'b10))
                    mode_next[`MODE_PREC_MSB:`MODE_PREC_LSB] = {exec_word[0], exec_word[1]};
                else
                    mode_next[`MODE_PREC_MSB:`MODE_PREC_LSB] = exec_word[1:0];
            end else if (exec_word[9:1] == 9'h00B) begin
                mode_next[`MODE_POST] = exec_word[0];
            end else if (exec_word[9:1] == 9'h009) begin
                mode_next[`MODE_TRANSP] = exec_word[0];
            end else if (exec_word[9:1] == 9'h00C) begin
                mode_next[`MODE_OBANK] = exec_word[0];
            end else if (exec_word[9:1] == 9'h00D) begin
                mode_next[`MODE_ABANK] = exec_word[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alternate holder next value; kept otherwise
    always @* begin
        alt_next = alternate_instruction_holder;
        if (load_pending_reg && instr_in != `OP_CTRL_RESET)
            alt_next = instr_in;
        else if (exec_valid && exec_word == `OP_WRITE_ALT)
            alt_next = data_in[IW-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sum and bit-reversed output; pre or post update by mode bit 9
    always @* begin
        sum_val = areg[areg_index] + oreg[oreg_index];
        rev_src = mode_reg[`MODE_POST] ? sum_val : areg[areg_index];
    end

    bit_reverse #(
        .WIDTH (DW)
    ) u_rev (
        .word_in  (rev_src),
        .word_out (rev_val)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg                     <= `MODE_RESET;
            alternate_instruction_holder <= `ALT_RESET;
            load_pending_reg             <= 1'b0;
            cond_fire_reg                <= 1'b0;
            for (k = 0; k < 16; k = k + 1)
                areg[k] <= {DW{1'b0}};
            for (k = 0; k < 8; k = k + 1)
                oreg[k] <= {DW{1'b0}};
        end else begin
            mode_reg                     <= mode_next;
            alternate_instruction_holder <= alt_next;
            // Arms only with chip select, so shared buses load selectively
            load_pending_reg <= exec_valid && exec_word == `OP_LOAD_ALT && chip_select_in;
            // True compare from a looping op fires the holder next cycle
            cond_fire_reg <= mode_reg[`MODE_CONDALT] && compare_true_in
                             && (op_class == C_INC || op_class == C_DEC
                                 || op_class == C_ADD || op_class == C_SUB);
            if (op_class == C_REV)
                areg[areg_index] <= sum_val;
            if (op_class == C_BTR)
                areg[areg_index] <= oreg[oreg_index];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus outputs, registered; no-op floats both
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            data_out <= {DW{1'b0}};
            data_oe  <= 1'b0;
            addr_out <= {DW{1'b0}};
            addr_oe  <= 1'b0;
        end else begin
            data_oe <= 1'b0;
            addr_oe <= 1'b0;
            if (op_class == C_ALT && exec_word == `OP_READ_ALT) begin
                data_out <= {{(DW-IW){1'b0}}, alternate_instruction_holder};
                data_oe  <= 1'b1;
            end else if (op_class == C_MODE && exec_word == `OP_MODE_TO_DATA) begin
                data_out <= {{(DW-11){1'b0}}, mode_reg};
                data_oe  <= 1'b1;
            end
            if (op_class == C_PASS) begin
                addr_out <= data_in;
                addr_oe  <= 1'b1;
            end else if (op_class == C_REV) begin
                addr_out <= rev_val;
                addr_oe  <= 1'b1;
            end
        end
    end
endmodule // addr_gen_decode

// ===== rtl/addr_gen_defs.vh
/*
 * Opcodes, mode word fields and reset values for the address generator
 * instruction decoder. Assumes a 10-bit instruction word and an 11-bit mode word.
 */
`ifndef ADDR_GEN_DEFS_VH
`define ADDR_GEN_DEFS_VH

// Exact opcodes
`define OP_NOP          10'h000
`define OP_CTRL_RESET   10'h001
`define OP_LOAD_ALT     10'h01E
`define OP_DATA_TO_ADDR 10'h01F
`define OP_WRITE_ALT    10'h02C
`define OP_READ_ALT     10'h02D
`define OP_DATA_TO_MODE 10'h02E
`define OP_MODE_TO_DATA 10'h02F

// Mode word field positions
`define MODE_INIT_LSB   0
`define MODE_PREC_LSB   4
`define MODE_PREC_MSB   5
`define MODE_TRANSP     6
`define MODE_ABANK      7
`define MODE_OBANK      8
`define MODE_POST       9
`define MODE_CONDALT    10

// Reset values
`define MODE_RESET      11'h000
`define ALT_RESET       10'h000

`endif

// ===== rtl/bit_reverse.v
/*
 * Reverses the bit order of a word.
 * Assumes a purely combinational use.
 */
`timescale 1ns/1ps
module bit_reverse #(
    parameter WIDTH = 16
) (
    // Data
    input  wire [WIDTH-1:0] word_in,
    output wire [WIDTH-1:0] word_out
);
    genvar i;
    // One wire per bit, swapped end for end
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_rev
            assign word_out[i] = word_in[WIDTH-1-i];
        end
    endgenerate
endmodule // bit_reverse

// ===== sim/addr_gen_decode_asserts.sv
/* Checker for the instruction decoder, watching the top module ports only.
   Assumes one clock, an asynchronous active-low reset and no conditional run unless flagged. */
`timescale 1ns/1ps
`include "addr_gen_defs.vh"
module addr_gen_decode_asserts #(
    parameter DW = 16,
    parameter IW = 10
) (
    // Clock and reset
    input wire          clk,
    input wire          rst_b,
    // Instruction side
    input wire [IW-1:0] instr_in,
    input wire          chip_select_in,
    input wire          alternate_exec_enable_in,
    // Buses and mode word
    input wire [DW-1:0] data_in,
    input wire [DW-1:0] data_out,
    input wire          data_oe,
    input wire [DW-1:0] addr_out,
    input wire          addr_oe,
    input wire [10:0]   mode_control_word,
    input wire [1:0]    precision_mode,
    input wire          reinit_allowed
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    reg  armed_reg;
    wire plain = !alternate_exec_enable_in && !mode_control_word[10] && !armed_reg;

    // Armed load marker, so the captured word is never taken for a command
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            armed_reg <= 1'b0;
        else
            armed_reg <= plain && instr_in == `OP_LOAD_ALT && chip_select_in;
    end

    chk_nop_floats: assert property (plain && instr_in == `OP_NOP |=> !data_oe && !addr_oe)
        else $error("no-op drove a bus");
    chk_pass_addr: assert property (plain && instr_in == `OP_DATA_TO_ADDR
        |=> addr_oe && addr_out == $past(data_in)) else $error("data not passed to address");
    chk_holder_trip: assert property (plain && instr_in == `OP_WRITE_ALT ##1 plain && instr_in == `OP_READ_ALT
        |=> data_oe && data_out[9:0] == $past(data_in[9:0], 2)) else $error("holder read mismatch");
    chk_mode_write: assert property (plain && instr_in == `OP_DATA_TO_MODE
        |=> mode_control_word == $past(data_in[10:0])) else $error("mode write mismatch");
    chk_mode_read: assert property (plain && instr_in == `OP_MODE_TO_DATA
        |=> data_oe && data_out[10:0] == $past(mode_control_word)) else $error("mode read mismatch");
    chk_reset_wins: assert property (instr_in == `OP_CTRL_RESET |=> mode_control_word == 11'h000)
        else $error("control reset not executed");
    chk_load_noop: assert property (plain && instr_in == `OP_LOAD_ALT && chip_select_in
        ##1 instr_in != `OP_CTRL_RESET |=> $stable(mode_control_word) && !data_oe && !addr_oe)
        else $error("captured word was executed");
    chk_prec_swap: assert property (plain && instr_in == 10'h029 && chip_select_in
        |=> precision_mode == 2'b10) else $error("precision not swapped");
    chk_bank_bit: assert property (plain && instr_in[9:1] == 9'h00C
        |=> mode_control_word[8] == $past(instr_in[0])) else $error("offset bank bit wrong");
    chk_cond_flag: assert property (plain && instr_in[9:1] == 9'h00A
        |=> reinit_allowed == !$past(instr_in[0])) else $error("conditional flag wrong");
endmodule // addr_gen_decode_asserts
////////////////////////////////////////////////////////////////////////////////
bind addr_gen_decode addr_gen_decode_asserts #(.DW(DW), .IW(IW)) u_asserts (
    .clk(clk), .rst_b(rst_b), .instr_in(instr_in), .chip_select_in(chip_select_in),
    .alternate_exec_enable_in(alternate_exec_enable_in), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .addr_out(addr_out), .addr_oe(addr_oe), .mode_control_word(mode_control_word),
    .precision_mode(precision_mode), .reinit_allowed(reinit_allowed));

// ===== sim/sequencer_model.sv
/* Sequencer model driving the instruction word, select, enables and data bus.
   Assumes the decoder samples everything on the rising edge. */
`timescale 1ns/1ps
module sequencer_model (
    // Clock
    input  wire         clk,
    // Instruction side
    output logic [9:0]  instr,
    output logic        select,
    output logic        alt_enable,
    output logic        compare,
    // Shared data bus, sequencer side
    output logic [15:0] data
);
    // Quiet bus at time zero
    initial begin
        instr = 10'h000;
        select = 1'b0;
        alt_enable = 1'b0;
        compare = 1'b0;
        data = 16'h0000;
    end

    // One word a clock, launched on the falling edge; select goes with each word as given
    task automatic issue(input logic [9:0] i, input logic c, input logic a, input logic k, input logic [15:0] d);
        @(negedge clk);
        instr <= i;
        select <= c;
        alt_enable <= a;
        compare <= k;
        data <= d;
    endtask

    // Bus not carrying data: show the inverse so a stale value never looks valid
    task automatic op(input logic [9:0] i);
        opd(i, ~data);
    endtask

    task automatic opd(input logic [9:0] i, input logic [15:0] d);
        issue(i, 1'b0, 1'b0, 1'b0, d);
    endtask
endmodule // sequencer_model

// ===== sim/test_address_generator_instruction_decode.sv
/* Testbench for the instruction decoder: holder, mode word, execution and decode.
   Assumes the sequencer model drives all inputs on the falling edge. */
`timescale 1ns/1ps
`include "addr_gen_defs.vh"
module test_address_generator_instruction_decode;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    wire  [9:0]  instr;
    wire         sel, alt, cmp, data_oe, addr_oe, transp, reinit;
    wire  [15:0] data, data_out, addr_out;
    wire  [10:0] mcw;
    wire  [1:0]  prec;
    wire  [4:0]  op_class;
    wire  [3:0]  areg;
    wire  [2:0]  oreg;
    int          failures = 0;
    int          checked = 0;
    int          cycles = 0;
    // Mode set opcodes, set then clear, and the mode bit each writes
    localparam logic [9:0] SET_OP [12] = '{10'h015, 10'h014, 10'h013, 10'h012, 10'h017, 10'h016,
                                          10'h019, 10'h018, 10'h01B, 10'h01A, 10'h025, 10'h024};
    localparam int         SET_BIT [12] = '{10, 10, 6, 6, 9, 9, 8, 8, 7, 7, 2, 2};
    // Group opcodes and the class the decoder reports
    localparam logic [9:0] DEC_OP [14] = '{10'h2C0, 10'h280, 10'h308, 10'h300, 10'h034, 10'h030, 10'h03C,
                                          10'h180, 10'h1C0, 10'h140, 10'h070, 10'h060, 10'h240, 10'h01F};
    localparam logic [4:0] DEC_CLS [14] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08,
                                           5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};

    sequencer_model seq (.clk(clk), .instr(instr), .select(sel), .alt_enable(alt), .compare(cmp), .data(data));
    addr_gen_decode DUT (
        .clk(clk), .rst_b(rst_b), .instr_in(instr), .chip_select_in(sel), .alternate_exec_enable_in(alt),
        .compare_true_in(cmp), .data_in(data), .data_out(data_out), .data_oe(data_oe), .addr_out(addr_out),
        .addr_oe(addr_oe), .mode_control_word(mcw), .precision_mode(prec), .transparent_mode(transp),
        .reinit_allowed(reinit), .op_class(op_class), .areg_index(areg), .oreg_index(oreg), .cnt_index());

    // 50 MHz clock
    always #10 clk = ~clk;

    // Hang guard, well above the fewer than 100 cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            failures++;
            $display("Error at %0t: run hung", $time);
            complete_run();
        end
    end
////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    // Each check reads the outputs of the word taken one edge before, except the #1 decode checks, which read the word just issued
    initial begin
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        check(16'({data_oe, addr_oe}), 16'h0000, "buses after reset");
        seq.opd(`OP_WRITE_ALT, 16'hFDA5);
        seq.op(`OP_READ_ALT);
        seq.op(`OP_LOAD_ALT);
        check(data_out, 16'h01A5, "holder read");
        seq.op(10'h019);
        seq.issue(`OP_LOAD_ALT, 1'b1, 1'b0, 1'b0, 16'h0000);
        seq.op(10'h018);
        seq.op(`OP_READ_ALT);
        check(16'(mcw[8]), 16'h0001, "captured word ran");
        check(16'({data_oe, addr_oe}), 16'h0000, "capture not a no-op");
        seq.issue(`OP_LOAD_ALT, 1'b1, 1'b0, 1'b0, 16'h0000);
        check(data_out, 16'h0018, "holder from instruction bus");
        seq.op(`OP_CTRL_RESET);
        seq.op(`OP_READ_ALT);
        seq.op(`OP_NOP);
        check(16'(mcw), 16'h0000, "reset after load");
        check(data_out, 16'h0018, "reset captured");
        $display("Holder test done");
        seq.opd(`OP_DATA_TO_MODE, 16'hFA9A);
        seq.op(`OP_MODE_TO_DATA);
        check(16'({prec, transp, reinit}), 16'h0005, "mode fields");
        seq.op(`OP_NOP);
        check(data_out, 16'h029A, "mode read back");
        for (int i = 0; i < 12; i++) begin
            seq.op(SET_OP[i]);
            seq.op(`OP_NOP);
            check(16'(mcw[SET_BIT[i]]), 16'(SET_OP[i][0]), "mode set bit");
        end
        seq.op(10'h029);
        seq.issue(10'h029, 1'b1, 1'b0, 1'b0, 16'h0000);
        check(16'(prec), 16'h0001, "precision plain");
        seq.issue(10'h02B, 1'b1, 1'b0, 1'b0, 16'h0000);
        check(16'(prec), 16'h0002, "precision swap");
        seq.op(`OP_NOP);
        check(16'(prec), 16'h0003, "precision symmetric");
        $display("Mode test done");
        seq.opd(`OP_WRITE_ALT, 16'h0013);
        seq.issue(`OP_NOP, 1'b0, 1'b1, 1'b0, 16'h0000);
        seq.opd(`OP_WRITE_ALT, 16'h0001);
        check(16'(transp), 16'h0001, "holder run by enable");
        seq.op(10'h012);
        seq.issue(`OP_NOP, 1'b0, 1'b1, 1'b0, 16'h0000);
        seq.opd(`OP_WRITE_ALT, 16'h0013);
        check(16'(mcw), 16'h003A, "reset from holder ran");
        seq.issue(`OP_CTRL_RESET, 1'b0, 1'b1, 1'b0, 16'h0000);
        seq.op(10'h015);
        check(16'(mcw), 16'h0000, "reset lost to holder");
        seq.issue(10'h2C0, 1'b0, 1'b0, 1'b1, 16'h0000);
        seq.op(`OP_NOP);
        seq.op(`OP_CTRL_RESET);
        check(16'({transp, reinit}), 16'h0002, "holder run on compare");
        seq.issue(10'h2C0, 1'b0, 1'b0, 1'b1, 16'h0000);
        seq.op(`OP_NOP);
        seq.op(`OP_NOP);
        check(16'(transp), 16'h0000, "run with mode clear");
        $display("Execute test done");
        seq.opd(`OP_DATA_TO_ADDR, 16'hBEEF);
        seq.op(`OP_NOP);
        check(addr_out, 16'hBEEF, "data to address");
        check(16'({data_oe, addr_oe}), 16'h0001, "address drive");
        seq.op(10'h019);
        check(16'({data_oe, addr_oe}), 16'h0000, "no-op drove");
        seq.op(10'h01B);
        for (int i = 0; i < 14; i++) begin
            seq.op(DEC_OP[i]);
            #1 check(16'(op_class), 16'(DEC_CLS[i]), "decode class");
        end
        seq.op(10'h250);
        #1 check(16'(oreg), 16'h0005, "offset index bank");
        seq.op(10'h30A);
        #1 check(16'(areg), 16'h000A, "address index bank");
        check(16'(addr_oe), 16'h0001, "reverse drive");
        $display("Decode test done");
        complete_run();
    end
endmodule // test_address_generator_instruction_decode
